// File: rtl/pil_pkg.sv
// constants, register map and carrier types of the project image card loader
// assumes a 250 MHz system clock and one AHB-Lite slave port
`default_nettype none

package pil_pkg;

	localparam int unsigned CLK_MHZ = 250;
	// lamp flash half period and self reset length, in their own units
	localparam int unsigned FLASH_HALF_MS = 250;
	localparam int unsigned FLASH_HALF_CYC = FLASH_HALF_MS * 1000 * CLK_MHZ;
	localparam int unsigned SELF_RST_MS = 2;
	localparam int unsigned SELF_RST_CYC = SELF_RST_MS * 1000 * CLK_MHZ;
	// cycles after reset release before straps are trusted
	localparam logic [1:0] STRAP_SETTLE = 2'h3;

	localparam int unsigned WORD_BITS = 32;
	localparam int unsigned AW = 16;

	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_REQ = 8'h04;
	localparam logic [7:0] ADDR_STAT = 8'h08;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h0c;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
	localparam logic [7:0] ADDR_PROJ_LEN = 8'h14;
	localparam logic [7:0] ADDR_FW_LEN = 8'h18;
	localparam logic [7:0] ADDR_PROGRESS = 8'h1c;

	localparam int unsigned CTRL_TRIG_LSB = 0;
	localparam int unsigned CTRL_POST_EXEC = 2;
	localparam int unsigned CTRL_AUTO_FW = 3;
	localparam int unsigned CTRL_FW_WATCH = 4;
	localparam int unsigned REQ_STORE = 0;
	localparam int unsigned REQ_LOAD = 1;
	localparam int unsigned STAT_BUSY = 0;
	localparam int unsigned STAT_CARD = 1;
	localparam int unsigned STAT_LOCK = 2;
	localparam int unsigned STAT_EXEC = 3;
	localparam int unsigned STAT_STORING = 4;
	localparam int unsigned STAT_LOADING = 5;
	localparam int unsigned IRQ_DONE = 0;
	localparam int unsigned IRQ_NOCARD = 1;
	localparam int unsigned IRQ_LOCKED = 2;
	localparam int unsigned IRQ_REFUSED = 3;
	localparam int unsigned IRQ_W = 4;

	localparam logic [15:0] PROJ_LEN_RST = 16'h0100;
	localparam logic [15:0] FW_LEN_RST = 16'h0000;
	localparam logic [3:0] IRQ_MASK_RST = 4'h0;

	typedef enum logic [1:0] {
		PIL_TRIG_POWERUP,
		PIL_TRIG_RAM_EMPTY,
		PIL_TRIG_REQUEST
	} pil_trig_e;

	// field order follows the ctrl word: trig in the low bits
	typedef struct packed {
		logic fw_watch;
		logic auto_fw;
		logic post_exec;
		pil_trig_e trig;
	} pil_cfg_s;

	localparam pil_cfg_s CFG_RST = '{1'b0, 1'b0, 1'b0, PIL_TRIG_REQUEST};

	typedef enum logic [2:0] {
		ST_POR,
		ST_IDLE,
		ST_ST_FETCH,
		ST_ST_WAIT,
		ST_ST_SHIFT,
		ST_LD_SHIFT,
		ST_LD_WRITE,
		ST_SELF_RST
	} pil_state_e;

endpackage

`default_nettype wire

// File: rtl/pil_card_loader.sv
// project image card loader: stores user ram to the card, loads it back
// assumes a one-cycle-latency user ram port and a card that samples its
// data pin on the rising edge of its own clock and drives it on the falling edge
`default_nettype none

// How it works
// (R01) load on power-up, ram-empty, or request only
// (R02) ram-empty mode loads only without valid project
// (R03) power-up load ends in chosen run mode
// (R04) load path can carry a firmware image
// (R05) requester must be online in program mode
// (R06) no card: refuse request, report it
// (R07) no store while card write-locked
// (R08) store flashes both lamps, progress readable
// (R09) finished store triggers a self reset
// (R10) self reset shows red, ends steady green
// (R11) requested load also self resets
// (R12) power-up load replaces unstored edits
// (R13) requested load overwrites all user ram
// (R14) requester confirms store, never interrupts it
// (R15) requester buffers logs, writes card rarely
// (R16) auto firmware update off by default
// (R17) pulse requests, ignored while busy, busy flag
// (R18) card lamp shows card access
module pil_card_loader #(
	parameter logic [31:0] FLASH_HALF_CYC = pil_pkg::FLASH_HALF_CYC,
	parameter logic [31:0] SELF_RST_CYC = pil_pkg::SELF_RST_CYC
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output logic irq,
	input wire logic card_clk,
	input wire logic card_present,
	input wire logic card_wp,
	input wire logic card_dat_i,
	output logic card_dat_o,
	output logic card_dat_oe,
	input wire logic [1:0] strap_trig,
	input wire logic strap_post_exec,
	input wire logic prog_mode,
	input wire logic ram_valid,
	output logic [15:0] ram_addr,
	output logic ram_rd,
	input wire logic [31:0] ram_rdata,
	output logic ram_we,
	output logic fw_we,
	output logic [31:0] ram_wdata,
	output logic ctrl_reset,
	output logic exec_mode,
	output logic health_green,
	output logic health_red,
	output logic card_lamp
);
	pil_pkg::pil_state_e state_reg;
	pil_pkg::pil_cfg_s cfg_reg, strap_cfg;
	logic [6:0] sync1_reg, sync2_reg;
	logic [7:0] wr_addr_reg;
	logic [31:0] hrdata_reg, shift_reg, rst_cnt_reg, blink_cnt_reg;
	logic [15:0] proj_len_reg, fw_len_reg, addr_reg;
	logic [pil_pkg::IRQ_W-1:0] irq_stat_reg, irq_mask_reg, irq_ev;
	logic [16:0] word_cnt_reg;
	logic [4:0] bit_cnt_reg;
	logic [1:0] por_cnt_reg;
	logic clk_prev_reg, clk_rise, s_present, s_wp, s_dat, wr_pend_reg;
	logic irq_clr, powerup_reg, fw_phase_reg, exec_reg, blink_reg;
	logic store_req, load_req, req_any, idle, xfer, storing, loading;
	logic last_store, last_load, por_load, wait_done, start_store, start_load;

	// only the second stage is ever read
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			sync1_reg <= 7'h00;
			sync2_reg <= 7'h00;
			clk_prev_reg <= 1'b0;
		end
		else
		begin
			sync1_reg <= {strap_post_exec, strap_trig, card_dat_i, card_wp,
				card_present, card_clk};
			sync2_reg <= sync1_reg;
			clk_prev_reg <= sync2_reg[0];
		end
	end

	assign clk_rise = sync2_reg[0] & ~clk_prev_reg;
	assign s_present = sync2_reg[1];
	assign s_wp = sync2_reg[2];
	assign s_dat = sync2_reg[3];
	always_comb
	begin
		strap_cfg = pil_pkg::CFG_RST;
		strap_cfg.post_exec = sync2_reg[6];
		if (sync2_reg[5:4] != 2'h3)
			strap_cfg.trig = pil_pkg::pil_trig_e'(sync2_reg[5:4]);
	end

	// ahb-lite: zero wait; read data latched in the address phase
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_reg;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			hrdata_reg <= 32'h0000_0000;
		end
		else if (hready)
		begin
			wr_pend_reg <= hsel & htrans[1] & hwrite;
			wr_addr_reg <= haddr[7:0];
			if (hsel & htrans[1] & ~hwrite)
			begin
				case (haddr[7:0])
				pil_pkg::ADDR_CTRL: hrdata_reg <= {27'h0, cfg_reg};
				pil_pkg::ADDR_STAT: hrdata_reg <= {26'h0, loading, storing,
					exec_reg, s_wp, s_present, ~idle};
				pil_pkg::ADDR_IRQ_STAT: hrdata_reg <= {28'h0, irq_stat_reg};
				pil_pkg::ADDR_IRQ_MASK: hrdata_reg <= {28'h0, irq_mask_reg};
				pil_pkg::ADDR_PROJ_LEN: hrdata_reg <= {16'h0, proj_len_reg};
				pil_pkg::ADDR_FW_LEN: hrdata_reg <= {16'h0, fw_len_reg};
				pil_pkg::ADDR_PROGRESS: hrdata_reg <= {15'h0, word_cnt_reg};
				default: hrdata_reg <= 32'h0000_0000;
				endcase
			end
		end
	end

	assign irq_clr = hready & hsel & htrans[1] & ~hwrite &
		(haddr[7:0] == pil_pkg::ADDR_IRQ_STAT);
	assign store_req = wr_pend_reg & (wr_addr_reg == pil_pkg::ADDR_REQ) &
		hwdata[pil_pkg::REQ_STORE];
	assign load_req = wr_pend_reg & (wr_addr_reg == pil_pkg::ADDR_REQ) &
		hwdata[pil_pkg::REQ_LOAD];
	assign req_any = store_req | load_req;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cfg_reg <= pil_pkg::CFG_RST;
			proj_len_reg <= pil_pkg::PROJ_LEN_RST;
			fw_len_reg <= pil_pkg::FW_LEN_RST;
			irq_mask_reg <= pil_pkg::IRQ_MASK_RST;
		end
		else if (state_reg == pil_pkg::ST_POR && por_cnt_reg ==
			pil_pkg::STRAP_SETTLE)
			cfg_reg <= strap_cfg; // R01 R03
		else if (wr_pend_reg)
		begin
			case (wr_addr_reg)
			pil_pkg::ADDR_CTRL:
			begin
				cfg_reg <= hwdata[4:0];
				if (hwdata[1:0] == 2'h3)
					cfg_reg.trig <= pil_pkg::PIL_TRIG_REQUEST;
			end
			pil_pkg::ADDR_PROJ_LEN: proj_len_reg <= hwdata[15:0];
			pil_pkg::ADDR_FW_LEN: fw_len_reg <= hwdata[15:0];
			pil_pkg::ADDR_IRQ_MASK: irq_mask_reg <= hwdata[3:0];
			default: ;
			endcase
		end
	end

	assign idle = state_reg == pil_pkg::ST_IDLE;
	assign storing = state_reg == pil_pkg::ST_ST_FETCH ||
		state_reg == pil_pkg::ST_ST_WAIT || state_reg == pil_pkg::ST_ST_SHIFT;
	assign loading = state_reg == pil_pkg::ST_LD_SHIFT ||
		state_reg == pil_pkg::ST_LD_WRITE;
	assign xfer = storing | loading;
	// a load wins nothing over a store written in the same word
	assign start_store = idle & store_req & s_present & ~s_wp & prog_mode;
	assign start_load = idle & load_req & ~store_req & s_present & prog_mode;
	assign last_store = 17'(word_cnt_reg + 17'h1) == {1'b0, proj_len_reg};
	assign last_load = 17'(word_cnt_reg + 17'h1) ==
		17'({1'b0, proj_len_reg} + {1'b0, fw_len_reg});
	assign por_load = s_present &&
		(strap_cfg.trig == pil_pkg::PIL_TRIG_POWERUP ||
		(strap_cfg.trig == pil_pkg::PIL_TRIG_RAM_EMPTY && !ram_valid));
	assign wait_done = rst_cnt_reg == 32'(SELF_RST_CYC - 32'h1);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_reg <= pil_pkg::ST_POR;
			por_cnt_reg <= 2'h0;
			word_cnt_reg <= 17'h0;
			bit_cnt_reg <= 5'h0;
			addr_reg <= 16'h0;
			shift_reg <= 32'h0;
			rst_cnt_reg <= 32'h0;
			powerup_reg <= 1'b0;
			fw_phase_reg <= 1'b0;
		end
		else
		begin
			case (state_reg)
			pil_pkg::ST_POR:
			begin
				por_cnt_reg <= 2'(por_cnt_reg + 2'h1);
				if (por_cnt_reg == pil_pkg::STRAP_SETTLE)
				begin
					fw_phase_reg <= proj_len_reg == 16'h0;
					powerup_reg <= por_load;
					state_reg <= por_load ? pil_pkg::ST_LD_SHIFT // R01 R02 R12
						: pil_pkg::ST_IDLE;
				end
			end
			pil_pkg::ST_IDLE:
			begin
				word_cnt_reg <= 17'h0;
				bit_cnt_reg <= 5'h0;
				addr_reg <= 16'h0;
				powerup_reg <= 1'b0;
				rst_cnt_reg <= 32'h0;
				fw_phase_reg <= proj_len_reg == 16'h0;
				if (start_store) // R06 R07 R05
					state_reg <= pil_pkg::ST_ST_FETCH;
				else if (start_load)
					state_reg <= pil_pkg::ST_LD_SHIFT; // R13
			end
			pil_pkg::ST_ST_FETCH: state_reg <= pil_pkg::ST_ST_WAIT;
			pil_pkg::ST_ST_WAIT:
			begin
				shift_reg <= ram_rdata;
				state_reg <= pil_pkg::ST_ST_SHIFT;
			end
			pil_pkg::ST_ST_SHIFT:
			begin
				// a running store cannot be cancelled from the bus
				if (clk_rise) // R14
				begin
					shift_reg <= {shift_reg[30:0], 1'b0};
					bit_cnt_reg <= 5'(bit_cnt_reg + 5'h1);
					if (bit_cnt_reg == 5'h1f)
					begin
						word_cnt_reg <= 17'(word_cnt_reg + 17'h1);
						addr_reg <= 16'(addr_reg + 16'h1);
						state_reg <= last_store ? pil_pkg::ST_SELF_RST // R09
							: pil_pkg::ST_ST_FETCH;
					end
				end
			end
			pil_pkg::ST_LD_SHIFT:
			begin
				if (clk_rise)
				begin
					shift_reg <= {shift_reg[30:0], s_dat};
					bit_cnt_reg <= 5'(bit_cnt_reg + 5'h1);
					if (bit_cnt_reg == 5'h1f)
						state_reg <= pil_pkg::ST_LD_WRITE;
				end
			end
			pil_pkg::ST_LD_WRITE:
			begin
				// every project word is written; firmware words only when auto_fw is set
				word_cnt_reg <= 17'(word_cnt_reg + 17'h1); // R13 R12
				addr_reg <= 16'(addr_reg + 16'h1);
				if (!fw_phase_reg && 16'(addr_reg + 16'h1) == proj_len_reg)
				begin
					fw_phase_reg <= 1'b1; // R04
					addr_reg <= 16'h0;
				end
				state_reg <= last_load ? pil_pkg::ST_SELF_RST // R11
					: pil_pkg::ST_LD_SHIFT;
			end
			pil_pkg::ST_SELF_RST:
			begin
				rst_cnt_reg <= 32'(rst_cnt_reg + 32'h1);
				if (wait_done)
					state_reg <= pil_pkg::ST_IDLE;
			end
			default: state_reg <= pil_pkg::ST_IDLE;
			endcase
		end
	end

	// mode after a load: chosen mode on power-up, program mode otherwise
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			exec_reg <= 1'b0;
		else if (xfer)
			exec_reg <= 1'b0;
		else if (state_reg == pil_pkg::ST_SELF_RST && wait_done)
			exec_reg <= powerup_reg & cfg_reg.post_exec; // R03
	end

	// the flash phase restarts at each transfer so the lamps light at once
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			blink_cnt_reg <= 32'h0;
			blink_reg <= 1'b1;
		end
		else if (!xfer || blink_cnt_reg == 32'(FLASH_HALF_CYC - 32'h1))
		begin
			blink_cnt_reg <= 32'h0;
			blink_reg <= ~xfer | ~blink_reg;
		end
		else
			blink_cnt_reg <= 32'(blink_cnt_reg + 32'h1);
	end

	assign irq_ev[pil_pkg::IRQ_DONE] = state_reg == pil_pkg::ST_SELF_RST &&
		wait_done;
	assign irq_ev[pil_pkg::IRQ_NOCARD] = idle & req_any & ~s_present; // R06
	assign irq_ev[pil_pkg::IRQ_LOCKED] = idle & store_req & s_present & s_wp;
	assign irq_ev[pil_pkg::IRQ_REFUSED] = req_any & (~idle | ~prog_mode); // R17

	// set wins over the clear-on-read
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			irq_stat_reg <= 4'h0;
		else
			irq_stat_reg <= (irq_stat_reg & ~{4{irq_clr}}) | irq_ev;
	end

	assign irq = |(irq_stat_reg & irq_mask_reg);
	assign ram_addr = addr_reg;
	assign ram_wdata = shift_reg;
	assign ram_rd = state_reg == pil_pkg::ST_ST_FETCH;
	assign ram_we = state_reg == pil_pkg::ST_LD_WRITE && !fw_phase_reg;
	// firmware words are dropped unless automatic update is enabled
	assign fw_we = state_reg == pil_pkg::ST_LD_WRITE && fw_phase_reg &&
		cfg_reg.auto_fw; // R04 R16
	assign card_dat_o = storing & shift_reg[31];
	assign card_dat_oe = storing;
	assign ctrl_reset = state_reg == pil_pkg::ST_SELF_RST;
	assign exec_mode = exec_reg;
	assign health_green = idle | (xfer & blink_reg); // R08 R10
	assign health_red = state_reg == pil_pkg::ST_SELF_RST; // R10
	assign card_lamp = xfer & blink_reg; // R18 R08

	no_card_a: assert property (@(posedge hclk) disable iff (!hresetn) // R06
		(idle && req_any && !s_present) |=> (state_reg == pil_pkg::ST_IDLE
		&& irq_stat_reg[pil_pkg::IRQ_NOCARD]))
		else $error("request started without a card");
	lock_block_a: assert property (@(posedge hclk) disable iff (!hresetn) // R07
		(idle && store_req && s_wp) |=> state_reg != pil_pkg::ST_ST_FETCH)
		else $error("store started on a locked card");
	store_lamps_a: assert property (@(posedge hclk) disable iff (!hresetn) // R08
		storing |-> (card_dat_oe && health_green == card_lamp && !health_red))
		else $error("store lamps wrong");
	store_reset_a: assert property (@(posedge hclk) disable iff (!hresetn) // R09
		(state_reg == pil_pkg::ST_ST_SHIFT && clk_rise && bit_cnt_reg == 5'h1f
		&& last_store) |=> ctrl_reset ##1 ctrl_reset)
		else $error("no self reset after store");
	reset_red_a: assert property (@(posedge hclk) disable iff (!hresetn) // R10
		ctrl_reset |-> (health_red && !health_green && !card_lamp))
		else $error("health lamp not red in self reset");
	reset_end_a: assert property (@(posedge hclk) disable iff (!hresetn) // R10
		$fell(ctrl_reset) |-> (health_green && !health_red && !card_lamp
		&& idle))
		else $error("lamps wrong after self reset");
	busy_ignore_a: assert property (@(posedge hclk) disable iff (!hresetn) // R17
		(xfer && req_any) |=> (irq_stat_reg[pil_pkg::IRQ_REFUSED]
		&& $stable(word_cnt_reg[16]) && !idle))
		else $error("busy request not refused");
	post_mode_a: assert property (@(posedge hclk) disable iff (!hresetn) // R03
		($fell(ctrl_reset) && $past(powerup_reg)) |-> exec_mode ==
		cfg_reg.post_exec)
		else $error("post-load mode wrong");
	fw_gate_a: assert property (@(posedge hclk) disable iff (!hresetn) // R16
		fw_we |-> (cfg_reg.auto_fw && !ram_we && loading))
		else $error("firmware written without update enabled");
	empty_skip_a: assert property (@(posedge hclk) disable iff (!hresetn) // R02
		(state_reg == pil_pkg::ST_POR && por_cnt_reg == pil_pkg::STRAP_SETTLE
		&& strap_cfg.trig == pil_pkg::PIL_TRIG_RAM_EMPTY && ram_valid)
		|=> idle)
		else $error("ram-empty load with valid ram");
endmodule

`default_nettype wire

// File: testbench/pil_card_model.sv
// card model: clocks the link while run is high, captures stored words
// assumes the loader shifts msb first and samples on the clock's rise
`default_nettype none
module pil_card_model (
	output logic card_clk,
	output logic card_dat_i,
	input wire logic card_dat_o,
	input wire logic card_dat_oe,
	input wire logic run,
	output logic [31:0] st_word,
	output logic st_vld
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [31:0] ld;
	logic got;
	int nb;
	int nw;
	function automatic logic [31:0] pat(int n);
		return 32'hc3a50000 | n[15:0];
	endfunction
	initial
	begin
		card_clk = 1'b0;
		card_dat_i = 1'b1;
		st_vld = 1'b0;
		st_word = 32'h0;
		forever
		begin
			wait (run === 1'b1);
			nb = 0;
			nw = 0;
			got = 1'b0;
			ld = pat(0);
			card_dat_i = ld[31];
			while (run === 1'b1)
			begin
				#62.5 card_clk = 1'b1;
				st_vld = 1'b0;
				if (card_dat_oe === 1'b1)
					st_word = {st_word[30:0], card_dat_o};
				got = got | (card_dat_oe === 1'b1);
				nb++;
				#62.5 card_clk = 1'b0;
				ld = ld << 1;
				if (nb == 32)
				begin
					st_vld = got;
					nb = 0;
					got = 1'b0;
					nw++;
					ld = pat(nw);
				end
				card_dat_i = ld[31];
			end
			// released line flips so a stale sample cannot pass
			card_dat_i = ~card_dat_i;
		end
	end
endmodule
`default_nettype wire

// File: testbench/pil_card_loader_bench.sv
// self-checking bench of the card loader: bus master, ram stub, card model
// assumes the zero-wait bus port and the card model beside the loader
`default_nettype none
module pil_card_loader_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, ram_rdata = 32'h0;
	logic [1:0] htrans = 2'h0, strap_trig = 2'h2;
	logic [2:0] hsize = 3'h2;
	logic card_present = 1'b1, card_wp = 1'b0, run = 1'b0;
	logic strap_post_exec = 1'b0, ram_valid = 1'b1;
	logic prog_mode = 1'b1;
	logic hready, hreadyout, hresp, irq, card_clk, card_dat_i, card_dat_o;
	logic card_dat_oe, ram_rd, ram_we, fw_we, ctrl_reset, exec_mode, st_vld;
	logic health_green, health_red, card_lamp;
	logic [31:0] hrdata, ram_wdata, st_word, rd_val, sbase;
	logic [15:0] ram_addr;
	int num_errors = 0;
	int tests_run = 0;
	logic [31:0] q_reg[$];
	logic [48:0] q_dat[$];
	logic [48:0] q_card[$];
	event rd_ev;
	assign hready = hreadyout;
	pil_card_loader #(.FLASH_HALF_CYC(32'h8), .SELF_RST_CYC(32'h14))
	u_pil_card_loader (
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready, .hreadyout, .hresp, .hrdata, .irq, .card_clk, .card_present,
		.card_wp, .card_dat_i, .card_dat_o, .card_dat_oe, .strap_trig,
		.strap_post_exec, .prog_mode, .ram_valid, .ram_addr, .ram_rd,
		.ram_rdata, .ram_we, .fw_we, .ram_wdata, .ctrl_reset, .exec_mode,
		.health_green, .health_red, .card_lamp
	);
	pil_card_model u_pil_card_model (.card_clk, .card_dat_i, .card_dat_o,
		.card_dat_oe, .run, .st_word, .st_vld);
	always #2 hclk = ~hclk;
	// ram stub: random base mixed with the address, so a wrong word shows
	always @(posedge hclk)
		if (ram_rd === 1'b1)
			ram_rdata <= sbase ^ {16'h0, ram_addr};
	function automatic logic [31:0] pat(int n);
		return 32'hc3a50000 | n[15:0];
	endfunction
	task automatic summarize();
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(logic [48:0] g, logic [48:0] e);
		tests_run++;
		if (g !== e)
		begin
			num_errors++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic tmo();
		num_errors++;
		$display("CHECK FAILED t=%0t wait ran out", $time);
		summarize();
	endtask
	// k: 0 bus ready, 1 expected ram words drained, 2 self reset level v
	task automatic wt(int k, logic v);
		int n;
		n = 0;
		do
		begin
			@(posedge hclk);
			n++;
			if (n > 30000) tmo();
		end
		while (k == 0 ? hready !== 1'b1 :
			k == 1 ? q_dat.size() != 0 : ctrl_reset !== v);
	endtask
	task automatic bus(logic [7:0] a, logic w, logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		wt(0, 1'b0);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		wt(0, 1'b0);
		rd_val = hrdata;
	endtask
	task automatic rd(logic [7:0] a, logic [31:0] e);
		q_reg.push_back(e);
		bus(a, 1'b0, 32'h0);
		->rd_ev;
	endtask
	always @(rd_ev)
		chk(rd_val, q_reg.pop_front());
	always @(posedge hclk)
		if (ram_we === 1'b1 || fw_we === 1'b1)
			chk({fw_we, ram_addr, ram_wdata},
				q_dat.size() ? q_dat.pop_front() : '1);
	always @(posedge st_vld)
		chk({17'h0, st_word}, q_card.size() ? q_card.pop_front() : '1);
	task automatic por(logic [1:0] t, logic pe, logic rv);
		hresetn <= 1'b0;
		strap_trig <= t;
		strap_post_exec <= pe;
		ram_valid <= rv;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (8) @(posedge hclk);
	endtask
	// the model may be mid period: give it a full one to see run drop
	task automatic stop_card();
		run <= 1'b0;
		repeat (40) @(posedge hclk);
	endtask
	task automatic refuse(logic pm, logic cp, logic wp, logic [1:0] rq,
		logic [31:0] f);
		prog_mode <= pm;
		card_present <= cp;
		card_wp <= wp;
		repeat (6) @(posedge hclk);
		bus(pil_pkg::ADDR_REQ, 1'b1, {30'h0, rq});
		repeat (3) @(posedge hclk);
		chk(irq, 1'b1);
		chk(hresp, 1'b0);
		rd(pil_pkg::ADDR_IRQ_STAT, f);
		rd(pil_pkg::ADDR_STAT, {29'h0, wp, cp, 1'b0});
		chk(irq, 1'b0);
	endtask
	task automatic pul(int n);
		for (int i = 0; i < n; i++)
			q_dat.push_back({1'b0, i[15:0], pat(i)});
		run <= 1'b1;
		wt(1, 1'b0);
		rd(pil_pkg::ADDR_STAT, 32'h23);
		rd(pil_pkg::ADDR_PROGRESS, 32'(n));
		stop_card();
	endtask
	initial
	begin
		sbase = $urandom(49292);
		por(2'h2, 1'b0, 1'b1);
		rd(pil_pkg::ADDR_CTRL, 32'h2);
		rd(pil_pkg::ADDR_PROJ_LEN, 32'h100);
		rd(pil_pkg::ADDR_FW_LEN, 32'h0);
		rd(pil_pkg::ADDR_IRQ_MASK, 32'h0);
		rd(8'h20, 32'h0);
		bus(pil_pkg::ADDR_STAT, 1'b1, 32'hffffffff);
		rd(pil_pkg::ADDR_STAT, 32'h2);
		chk({health_green, card_lamp}, 2'h2);
		bus(pil_pkg::ADDR_PROJ_LEN, 1'b1, 32'h2);
		bus(pil_pkg::ADDR_FW_LEN, 1'b1, 32'h1);
		// trig code 3 must fold to request only; fw_watch is stored only
		bus(pil_pkg::ADDR_CTRL, 1'b1, 32'h1b);
		rd(pil_pkg::ADDR_CTRL, 32'h1a);
		q_card.push_back({17'h0, sbase});
		q_card.push_back({17'h0, sbase ^ 32'h1});
		// confirmed store, with a load request sent while it runs
		bus(pil_pkg::ADDR_REQ, 1'b1, 32'h1);
		run <= 1'b1;
		rd(pil_pkg::ADDR_STAT, 32'h13);
		chk(card_dat_oe, 1'b1);
		bus(pil_pkg::ADDR_REQ, 1'b1, 32'h2);
		wt(2, 1'b1);
		chk({health_red, health_green, card_lamp}, 3'h4);
		stop_card();
		wt(2, 1'b0);
		@(posedge hclk);
		chk({health_red, health_green, card_lamp, irq}, 4'h4);
		chk(q_card.size(), 0);
		rd(pil_pkg::ADDR_IRQ_STAT, 32'h9);
		rd(pil_pkg::ADDR_IRQ_STAT, 32'h0);
		bus(pil_pkg::ADDR_IRQ_MASK, 1'b1, 32'hf);
		refuse(1'b0, 1'b1, 1'b0, 2'h1, 32'h8);
		refuse(1'b1, 1'b0, 1'b0, 2'h2, 32'h2);
		refuse(1'b1, 1'b1, 1'b1, 2'h1, 32'h4);
		q_dat.push_back({1'b0, 16'h0, pat(0)});
		q_dat.push_back({1'b0, 16'h1, pat(1)});
		q_dat.push_back({1'b1, 16'h0, pat(2)});
		bus(pil_pkg::ADDR_REQ, 1'b1, 32'h2);
		run <= 1'b1;
		rd(pil_pkg::ADDR_STAT, 32'h27);
		wt(2, 1'b1);
		stop_card();
		wt(2, 1'b0);
		@(posedge hclk);
		chk({exec_mode, health_red, health_green, card_lamp, irq},
			5'h05);
		rd(pil_pkg::ADDR_IRQ_STAT, 32'h1);
		chk(q_dat.size(), 0);
		card_wp <= 1'b0;
		por(2'h1, 1'b0, 1'b1);
		rd(pil_pkg::ADDR_STAT, 32'h2);
		por(2'h1, 1'b0, 1'b0);
		pul(2);
		por(2'h0, 1'b1, 1'b1);
		// shorten the running power-up load to one word so it completes
		bus(pil_pkg::ADDR_PROJ_LEN, 1'b1, 32'h1);
		q_dat.push_back({1'b0, 16'h0, pat(0)});
		run <= 1'b1;
		wt(2, 1'b1);
		stop_card();
		wt(2, 1'b0);
		@(posedge hclk);
		chk({exec_mode, health_red, health_green, card_lamp, irq},
			5'h14);
		rd(pil_pkg::ADDR_STAT, 32'ha);
		rd(pil_pkg::ADDR_IRQ_STAT, 32'h1);
		chk(q_dat.size(), 0);
		summarize();
	end
endmodule
`default_nettype wire
